// file: src/srocpk_top.sv
/*
 Serial eight-channel relay sink controller: shift register, output latches,
 daisy-chain output, reset/set forcing and power-save gating.
 Assumes every pin input is asynchronous to sys_clk and sampled here.
*/
module srocpk_top (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Serial link pins
    input  wire logic       chipSelectN,
    input  wire logic       serialClk,
    input  wire logic       serialDataIn,
    output logic            serialDataOut,
    // Forcing pins
    input  wire logic       resetN,
    input  wire logic       setN,
    // Power-save pin
    input  wire logic       power_save_ctl,
    // Open-drain coil sinks: output level and enable per channel, then the per-channel power-save flags
    output logic [7:0]      coilSinkOut,
    output logic [7:0]      coilSinkOe,
    output logic [7:0]      powerSaveActive
);
    logic       csS;
    logic       sclkS;
    logic       dinS;
    logic       resetNS;
    logic       setNS;
    logic       psS;
    logic       csPrev_q;
    logic       sclkPrev_q;
    logic [7:0] shift_q;
    logic [7:0] latch_q;
    logic       forceClear;
    logic       forceSet;
    logic       sclkRise;
    logic       sclkFall;
    logic       csRise;

    // Every pin passes two flip-flops that reset to its idle level, so no false edge follows reset.
    srocpk_sync #(
        .RESET_LEVEL (srocpk_pkg::LEVEL_HIGH)
    ) uCs (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn (chipSelectN),
        .syncOut (csS)
    );

    srocpk_sync #(
        .RESET_LEVEL (srocpk_pkg::LEVEL_LOW)
    ) uSclk (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn (serialClk),
        .syncOut (sclkS)
    );

    srocpk_sync #(
        .RESET_LEVEL (srocpk_pkg::LEVEL_LOW)
    ) uDin (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn (serialDataIn),
        .syncOut (dinS)
    );

    srocpk_sync #(
        .RESET_LEVEL (srocpk_pkg::LEVEL_HIGH)
    ) uRst (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn (resetN),
        .syncOut (resetNS)
    );

    srocpk_sync #(
        .RESET_LEVEL (srocpk_pkg::LEVEL_HIGH)
    ) uSet (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn (setN),
        .syncOut (setNS)
    );

    srocpk_sync #(
        .RESET_LEVEL (srocpk_pkg::LEVEL_LOW)
    ) uPs (
        .sys_clk (sys_clk),
        .rst     (rst),
        .asyncIn (power_save_ctl),
        .syncOut (psS)
    );

    // Reset wins over set; both are levels, not edges.
    assign forceClear = (resetNS == srocpk_pkg::LEVEL_LOW);
    assign forceSet   = (setNS == srocpk_pkg::LEVEL_LOW) && !forceClear;
    assign sclkRise   = sclkS && !sclkPrev_q;
    assign sclkFall   = !sclkS && sclkPrev_q;
    assign csRise     = csS && !csPrev_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            csPrev_q   <= srocpk_pkg::LEVEL_HIGH;
            sclkPrev_q <= srocpk_pkg::LEVEL_LOW;
        end else begin
            csPrev_q   <= csS;
            sclkPrev_q <= sclkS;
        end
    end

    // Shift register: MSB is the stage feeding the serial output.
    always_ff @(posedge sys_clk) begin
        if (rst || forceClear) begin
            shift_q <= srocpk_pkg::CLEARED_VALUE;
        end else if (forceSet) begin
            shift_q <= srocpk_pkg::SET_VALUE;
        end else if (!csS && sclkRise) begin
            shift_q <= {shift_q[srocpk_pkg::CHANNELS-2:0], dinS};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || forceClear) begin
            latch_q <= srocpk_pkg::CLEARED_VALUE;
        end else if (forceSet) begin
            latch_q <= srocpk_pkg::SET_VALUE;
        end else if (csRise) begin
            latch_q <= shift_q;
        end
    end

    // Serial output follows the last stage, refreshed on falling serial clock.
    always_ff @(posedge sys_clk) begin
        if (rst || forceClear) begin
            serialDataOut <= srocpk_pkg::LEVEL_LOW;
        end else if (forceSet) begin
            serialDataOut <= srocpk_pkg::LEVEL_HIGH;
        end else if (sclkFall) begin
            serialDataOut <= shift_q[srocpk_pkg::CHANNELS-1];
        end
    end

    // Open drain: drive low while the latch bit is active, release otherwise.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            coilSinkOut     <= srocpk_pkg::CLEARED_VALUE;
            coilSinkOe      <= srocpk_pkg::CLEARED_VALUE;
            powerSaveActive <= srocpk_pkg::CLEARED_VALUE;
        end else begin
            coilSinkOut     <= srocpk_pkg::CLEARED_VALUE;
            coilSinkOe      <= latch_q;
            powerSaveActive <= psS ? latch_q : srocpk_pkg::CLEARED_VALUE;
        end
    end

    // Checks work on the synchronised pins; each result is looked at one clock after its cause.
    a_reset_clears: assert property (@(posedge sys_clk) disable iff (rst)
        forceClear |=> (latch_q == srocpk_pkg::CLEARED_VALUE) && (shift_q == srocpk_pkg::CLEARED_VALUE))
        else $error("reset did not clear state");

    a_reset_beats_set: assert property (@(posedge sys_clk) disable iff (rst)
        (forceClear && setNS == srocpk_pkg::LEVEL_LOW) |=> latch_q == srocpk_pkg::CLEARED_VALUE)
        else $error("set won over reset");

    a_set_forces: assert property (@(posedge sys_clk) disable iff (rst)
        forceSet |=> latch_q == srocpk_pkg::SET_VALUE)
        else $error("set did not force latches");

    a_set_shift: assert property (@(posedge sys_clk) disable iff (rst)
        forceSet |=> shift_q == srocpk_pkg::SET_VALUE)
        else $error("set did not force shift register");

    a_set_dout: assert property (@(posedge sys_clk) disable iff (rst)
        forceSet |=> serialDataOut == srocpk_pkg::LEVEL_HIGH)
        else $error("set did not force serial output");

    a_clear_dout: assert property (@(posedge sys_clk) disable iff (rst)
        forceClear |=> serialDataOut == srocpk_pkg::LEVEL_LOW)
        else $error("reset did not clear serial output");

    a_latch_on_cs: assert property (@(posedge sys_clk) disable iff (rst)
        (csRise && !forceClear && !forceSet) |=> latch_q == $past(shift_q))
        else $error("latch missed chip select rise");

    a_latch_holds: assert property (@(posedge sys_clk) disable iff (rst)
        (!csRise && !forceClear && !forceSet) |=> $stable(latch_q))
        else $error("latch changed without cause");

    a_shift_selected: assert property (@(posedge sys_clk) disable iff (rst)
        (csS && !forceClear && !forceSet) |=> $stable(shift_q))
        else $error("shift while deselected");

    a_shift_in: assert property (@(posedge sys_clk) disable iff (rst)
        (!csS && sclkRise && !forceClear && !forceSet) |=> shift_q[0] == $past(dinS))
        else $error("data not sampled");

    a_shift_moves: assert property (@(posedge sys_clk) disable iff (rst)
        (!csS && sclkRise && !forceClear && !forceSet) |=>
            shift_q[srocpk_pkg::CHANNELS-1:1] == $past(shift_q[srocpk_pkg::CHANNELS-2:0]))
        else $error("shift register did not advance");

    a_dout_fall: assert property (@(posedge sys_clk) disable iff (rst)
        (sclkFall && !forceClear && !forceSet) |=> serialDataOut == $past(shift_q[srocpk_pkg::CHANNELS-1]))
        else $error("serial output wrong");

    a_dout_holds: assert property (@(posedge sys_clk) disable iff (rst)
        (!sclkFall && !forceClear && !forceSet) |=> $stable(serialDataOut))
        else $error("serial output changed off a falling edge");

    a_sink_map: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 coilSinkOe == $past(latch_q) && coilSinkOut == srocpk_pkg::CLEARED_VALUE)
        else $error("sink enable mismatch");

    a_power_save: assert property (@(posedge sys_clk) disable iff (rst)
        (!psS) |=> powerSaveActive == srocpk_pkg::CLEARED_VALUE)
        else $error("power save without request");

    a_ps_follows: assert property (@(posedge sys_clk) disable iff (rst)
        psS |=> powerSaveActive == $past(latch_q))
        else $error("power save not on active outputs");
endmodule // srocpk_top

// file: src/srocpk_pkg.sv
/*
 Constants shared by the relay output controller: channel count, reset
 and set values of the latches, synchroniser depth and power-save timing.
 Assumes a 40 MHz system clock.
*/
package srocpk_pkg;
    localparam int          CHANNELS      = 8;
    localparam int          SYNC_STAGES   = 2;
    localparam logic [7:0]  CLEARED_VALUE = 8'h00;
    localparam logic [7:0]  SET_VALUE     = 8'hFF;
    localparam int          CLK_HZ        = 40000000;
    localparam int          PS_CANCEL_MS  = 3;
    localparam int          PS_CANCEL_CYC = (PS_CANCEL_MS * (CLK_HZ / 1000));
    localparam logic [2:0]  HOLD_PCT_IDX  = 3'h0;
    localparam logic        LEVEL_LOW     = 1'h0;
    localparam logic        LEVEL_HIGH    = 1'h1;
endpackage

// file: src/srocpk_sync.sv
/*
 Two flip-flop synchroniser for one level from outside the clock domain.
 Assumes the input may change at any time relative to sys_clk.
*/
module srocpk_sync #(
    parameter logic RESET_LEVEL = 1'h0
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Level
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stage1_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stage1_q <= RESET_LEVEL;
            syncOut  <= RESET_LEVEL;
        end else begin
            stage1_q <= asyncIn;
            syncOut  <= stage1_q;
        end
    end
endmodule // srocpk_sync

// file: testbench/srocpk_master.sv
/*
 Serial bus master model for the relay controller: sends one frame at a time
 and records the daisy-chain output. Assumes a 200 ns serial clock period.
*/
module srocpk_master (
    // Serial link pins
    output logic       chipSelectN,
    output logic       serialClk,
    output logic       serialDataIn,
    input  wire logic  serialDataOut
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rx = 8'h00;
    initial begin
        chipSelectN = 1'b1;
        serialClk = 1'b0;
        serialDataIn = 1'b1;
    end
    // The serial clock stands low outside frames; released data shows the inverse bit.
    task automatic frame(input logic [7:0] data, input logic sel);
        chipSelectN = ~sel;
        #100;
        for (int i = 7; i >= 0; i--) begin
            serialDataIn = data[i];
            #100;
            serialClk = 1'b1;
            #100;
            rx = {rx[6:0], serialDataOut};
            serialClk = 1'b0;
        end
        serialDataIn = ~data[0];
        #100;
        chipSelectN = 1'b1;
        #100;
    endtask
endmodule // srocpk_master

// file: testbench/srocpk_top_bench.sv
/*
 Self-checking bench for the relay controller top.
 Assumes the serial master model drives the link pins.
*/
module srocpk_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic       resetN = 1'b1;
    logic       setN = 1'b1;
    logic       power_save_ctl = 1'b0;
    logic       chipSelectN;
    logic       serialClk;
    logic       serialDataIn;
    logic       serialDataOut;
    logic [7:0] coilSinkOut;
    logic [7:0] coilSinkOe;
    logic [7:0] powerSaveActive;
    int         mismatches = 0;
    int         n_tests = 0;
    always #12.5 sys_clk = ~sys_clk;
    srocpk_top DUT (.sys_clk(sys_clk), .rst(rst), .chipSelectN(chipSelectN), .serialClk(serialClk),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .resetN(resetN), .setN(setN),
        .power_save_ctl(power_save_ctl), .coilSinkOut(coilSinkOut), .coilSinkOe(coilSinkOe),
        .powerSaveActive(powerSaveActive));
    srocpk_master far (.chipSelectN(chipSelectN), .serialClk(serialClk), .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle();
        repeat (8) @(negedge sys_clk);
    endtask
    task automatic results();
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t_load();
        check(coilSinkOe, 8'h00);
        far.frame(8'hA5, 1'b1);
        settle();
        check(coilSinkOe, 8'hA5);
        check(coilSinkOut, 8'h00);
        far.frame(8'h0F, 1'b0);
        settle();
        check(coilSinkOe, 8'hA5);
    endtask
    task automatic t_chain();
        far.frame(8'h3C, 1'b1);
        far.frame(8'hC3, 1'b1);
        settle();
        check(far.rx, 8'h3C);
        check(coilSinkOe, 8'hC3);
    endtask
    task automatic t_power();
        @(posedge sys_clk) power_save_ctl <= 1'b1;
        settle();
        check(powerSaveActive, 8'hC3);
        @(posedge sys_clk) power_save_ctl <= 1'b0;
        settle();
        check(powerSaveActive, 8'h00);
    endtask
    task automatic t_force();
        @(posedge sys_clk) setN <= 1'b0;
        settle();
        check(coilSinkOe, 8'hFF);
        @(posedge sys_clk) resetN <= 1'b0;
        settle();
        check(coilSinkOe, 8'h00);
        @(posedge sys_clk) setN <= 1'b1;
        settle();
        check(coilSinkOe, 8'h00);
        @(posedge sys_clk) resetN <= 1'b1;
        settle();
        check(coilSinkOe, 8'h00);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        settle();
        t_load();
        t_chain();
        t_power();
        t_force();
        results();
    end
    initial begin
        #200000;
        mismatches++;
        results();
    end
endmodule // srocpk_top_bench
